/* File: logic/stacked_ram_die_select_logic.sv */
// Stacked RAM die select logic: two PSRAM dies and one SRAM die
// behind shared control pins and a 16-bit data bus.
// Assumes a host drives pins synchronous to CLK_SYS.
// Operation
// RULE1 - PSRAM selected while its select is low
// RULE2 - Deselected PSRAM: standby, data and wait released
// RULE3 - Each PSRAM select drives only its die
// RULE4 - Register enable high targets refresh/bus registers
// RULE5 - Mode low reaches config register, low power
// RULE6 - SRAM selected when both selects asserted
// RULE7 - Either SRAM select deasserted deselects SRAM
// RULE8 - Low byte enables open their data lanes
// RULE9 - High byte enables mask lanes fully; register and config writes ignore them and take all 16 bits
// RULE10 - Output enable low drives selected die outputs
// RULE11 - Write enable low; data taken on rise
// RULE12 - Host keeps one die selected at once
`timescale 1ns/1ns
`default_nettype none
module stacked_ram_die_select_logic #(
  parameter int AW = ram_die_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // PSRAM controls
  input  wire logic [1:0]  PRAM_SELECT_N,
  input  wire logic        PRAM_CFG_REG_ENABLE,
  input  wire logic        PRAM_MODE_N,
  input  wire logic        PRAM_ASYNC_ONLY,
  // SRAM controls
  input  wire logic        STATIC_RAM_SELECT_LOW,
  input  wire logic        STATIC_RAM_SELECT_HIGH,
  // Shared RAM strobes
  input  wire logic        RAM_OUTPUT_ENABLE_N,
  input  wire logic        RAM_WRITE_ENABLE_N,
  input  wire logic        RAM_UPPER_BYTE_ENABLE_N,
  input  wire logic        RAM_LOWER_BYTE_ENABLE_N,
  input  wire logic        RAM_REG_SELECT,
  // Address and data
  input  wire logic [AW-1:0] ADDR,
  input  wire logic [15:0] DQ_IN,
  output logic      [15:0] DQ_OUT,
  output logic      [15:0] DQ_OE,
  // Wait pin
  output logic             WAIT_OUT,
  output logic             WAIT_OE,
  // Status
  output logic [1:0]       PRAM_STANDBY,
  output logic             SRAM_STANDBY,
  output logic             PRAM_LOW_POWER
);
  localparam int DEPTH = 1 << AW;
  // Refuse address widths the arrays cannot serve
  if (AW < 1 || AW > 16) begin : g_bad_aw
    $error("Address width out of range");
  end

  ////////////////////////////////////////////////////////////////////
  // Die selection, fully combinational from the pins
  logic [1:0] pram_sel;
  logic       sram_sel;
  logic       any_sel;
  logic [1:0] die_idx;
  always_comb begin
    pram_sel = ~PRAM_SELECT_N; // RULE1 RULE3
    sram_sel = ~STATIC_RAM_SELECT_LOW & STATIC_RAM_SELECT_HIGH; // RULE6 RULE7
    any_sel  = |pram_sel | sram_sel;
    // Priority only matters if the host breaks single-select use
    if (pram_sel[0]) begin // RULE12
      die_idx = 2'd0;
    end else if (pram_sel[1]) begin
      die_idx = 2'd1;
    end else begin
      die_idx = 2'd2;
    end
  end

  // Target decode for the selected die
  ram_die_pkg::target_t target;
  always_comb begin
    target = ram_die_pkg::TGT_NONE;
    if (sram_sel && !(|pram_sel)) begin
      target = ram_die_pkg::TGT_ARRAY;
    end else if (|pram_sel) begin
      if (PRAM_ASYNC_ONLY) begin
        target = PRAM_MODE_N ? ram_die_pkg::TGT_ARRAY : ram_die_pkg::TGT_CFG; // RULE5
      end else if (PRAM_CFG_REG_ENABLE) begin
        target = RAM_REG_SELECT ? ram_die_pkg::TGT_BUSCTL : ram_die_pkg::TGT_REFRESH; // RULE4
      end else begin
        target = ram_die_pkg::TGT_ARRAY; // RULE4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Storage: per-die arrays and registers
  localparam int PRAM_DIE_CNT = ram_die_pkg::PRAM_DIES;
  logic [15:0] pram_mem [PRAM_DIE_CNT*DEPTH];
  logic [15:0] sram_mem [DEPTH];
  logic [15:0] refresh_reg_ff [2];
  logic [15:0] bus_reg_ff [2];
  logic [15:0] cfg_ff [2];
  logic        we_n_ff;
  logic [15:0] wdata_ff;
  logic [AW-1:0] waddr_ff;
  ram_die_pkg::target_t wtgt_ff;
  logic [1:0]  wdie_ff;
  logic        wub_n_ff;
  logic        wlb_n_ff;

  // Latch data while write enable is low; commit on its rise
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      we_n_ff  <= 1'b1;
      wdata_ff <= ram_die_pkg::DATA_RST;
      waddr_ff <= '0;
      wtgt_ff  <= ram_die_pkg::TGT_NONE;
      wdie_ff  <= 2'd0;
      wub_n_ff <= 1'b1;
      wlb_n_ff <= 1'b1;
    end else begin
      // Only a selected write arms the commit, so no stale write replays
      we_n_ff <= RAM_WRITE_ENABLE_N || !any_sel; // RULE7
      if (!RAM_WRITE_ENABLE_N && any_sel) begin // RULE11
        wdata_ff <= DQ_IN;
        waddr_ff <= ADDR;
        wtgt_ff  <= target;
        wdie_ff  <= die_idx;
        wub_n_ff <= RAM_UPPER_BYTE_ENABLE_N;
        wlb_n_ff <= RAM_LOWER_BYTE_ENABLE_N;
      end
    end
  end

  logic        commit;
  logic [15:0] old_word;
  logic [15:0] merged;
  logic [15:0] wr_mask;
  always_comb begin
    commit = RAM_WRITE_ENABLE_N && !we_n_ff; // RULE11
    case (wdie_ff)
      2'd0:    old_word = pram_mem[waddr_ff];
      2'd1:    old_word = pram_mem[DEPTH + waddr_ff];
      default: old_word = sram_mem[waddr_ff];
    endcase
  end

  ram_byte_lanes #(.W(16)) u_wr_lanes (
    .upper_n   (wub_n_ff),
    .lower_n   (wlb_n_ff),
    .old_word  (old_word),
    .new_word  (wdata_ff),
    .merged    (merged),
    .lane_mask (wr_mask)
  );

  // Array writes keep masked lanes untouched
  always_ff @(posedge CLK_SYS) begin
    if (commit && wtgt_ff == ram_die_pkg::TGT_ARRAY) begin
      case (wdie_ff)
        2'd0:    pram_mem[waddr_ff] <= merged; // RULE9
        2'd1:    pram_mem[DEPTH + waddr_ff] <= merged;
        default: sram_mem[waddr_ff] <= merged;
      endcase
    end
  end

  // Control registers, one set per PSRAM die
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      refresh_reg_ff <= '{ram_die_pkg::REFRESH_RST, ram_die_pkg::REFRESH_RST};
      bus_reg_ff     <= '{ram_die_pkg::BUSCTL_RST, ram_die_pkg::BUSCTL_RST};
      cfg_ff <= '{ram_die_pkg::CFG_RST, ram_die_pkg::CFG_RST};
    end else if (commit && wdie_ff != 2'd2) begin
      case (wtgt_ff)
        ram_die_pkg::TGT_REFRESH: refresh_reg_ff[wdie_ff[0]] <= wdata_ff; // RULE4
        ram_die_pkg::TGT_BUSCTL:  bus_reg_ff[wdie_ff[0]] <= wdata_ff; // RULE4
        ram_die_pkg::TGT_CFG: cfg_ff[wdie_ff[0]] <= wdata_ff; // RULE5
        default: ;
      endcase
    end
  end

  // Low-power entry and exit through a mode-gated config write
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PRAM_LOW_POWER <= 1'b0;
    end else if (commit && wtgt_ff == ram_die_pkg::TGT_CFG) begin
      PRAM_LOW_POWER <= wdata_ff[0]; // RULE5
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path and output drivers
  logic [15:0] rd_word;
  logic [15:0] rd_mask;
  logic        drive;
  always_comb begin
    case (target)
      ram_die_pkg::TGT_REFRESH: rd_word = refresh_reg_ff[die_idx[0]];
      ram_die_pkg::TGT_BUSCTL:  rd_word = bus_reg_ff[die_idx[0]];
      ram_die_pkg::TGT_CFG: rd_word = cfg_ff[die_idx[0]];
      ram_die_pkg::TGT_ARRAY: begin
        case (die_idx)
          2'd0:    rd_word = pram_mem[ADDR];
          2'd1:    rd_word = pram_mem[DEPTH + ADDR];
          default: rd_word = sram_mem[ADDR];
        endcase
      end
      default: rd_word = ram_die_pkg::DATA_RST;
    endcase
    // Never drive while the host writes
    drive = any_sel && !RAM_OUTPUT_ENABLE_N && RAM_WRITE_ENABLE_N; // RULE10
  end

  ram_byte_lanes #(.W(16)) u_rd_lanes (
    .upper_n   (RAM_UPPER_BYTE_ENABLE_N),
    .lower_n   (RAM_LOWER_BYTE_ENABLE_N),
    .old_word  (16'h0000),
    .new_word  (rd_word),
    .merged    (),
    .lane_mask (rd_mask)
  );

  // Registered outputs: one cycle behind the pins
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      DQ_OUT  <= ram_die_pkg::DATA_RST;
      DQ_OE   <= 16'h0000;
      WAIT_OUT <= 1'b0;
      WAIT_OE  <= 1'b0;
    end else begin
      DQ_OUT   <= rd_word & rd_mask;
      DQ_OE    <= drive ? rd_mask : 16'h0000; // RULE8 RULE9 RULE10
      WAIT_OUT <= 1'b0; // Asynchronous reads are always valid
      WAIT_OE  <= |pram_sel && !RAM_OUTPUT_ENABLE_N; // RULE2
    end
  end

  // Standby flags per die
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PRAM_STANDBY <= 2'b11;
      SRAM_STANDBY <= 1'b1;
    end else begin
      PRAM_STANDBY <= PRAM_SELECT_N; // RULE2
      SRAM_STANDBY <= ~sram_sel; // RULE7
    end
  end
endmodule // stacked_ram_die_select_logic
`default_nettype wire

/* File: logic/ram_die_pkg.sv */
// Package for the stacked RAM die select logic.
// Assumes the RAM dies share one 16-bit data bus and one clock.
`default_nettype none
package ram_die_pkg;
  localparam int          DATA_W      = 16;
  localparam int          LANE_W      = 8;
  localparam int          PRAM_DIES   = 2;
  localparam int          PRAM_WORDS  = 256;
  localparam int          SRAM_WORDS  = 256;
  localparam int          ADDR_W      = 8;
  localparam int          UPPER_LSB   = 8;
  localparam int          LOWER_LSB   = 0;
  localparam logic [15:0] DATA_RST    = 16'h0000;
  localparam logic [15:0] REFRESH_RST = 16'h0000;
  localparam logic [15:0] BUSCTL_RST  = 16'h0000;
  localparam logic [15:0] CFG_RST     = 16'h0000;
  // Access targets, decoded from the control pins
  typedef enum logic [2:0] {
    TGT_NONE    = 3'b000,
    TGT_ARRAY   = 3'b001,
    TGT_REFRESH = 3'b010,
    TGT_BUSCTL  = 3'b011,
    TGT_CFG     = 3'b100
  } target_t;
endpackage
`default_nettype wire

/* File: logic/ram_byte_lanes.sv */
// Byte-lane mask and write merge for one 16-bit RAM word.
// Assumes active-low byte enables sampled on the system clock.
`timescale 1ns/1ns
`default_nettype none
module ram_byte_lanes #(
  parameter int W = 16
) (
  // Lane enables, low true
  input  wire logic         upper_n,
  input  wire logic         lower_n,
  // Data
  input  wire logic [W-1:0] old_word,
  input  wire logic [W-1:0] new_word,
  output logic      [W-1:0] merged,
  output logic      [W-1:0] lane_mask
);
  localparam int H = W / 2;
  // Two equal lanes only
  if (W % 2 != 0) begin : g_bad_w
    $error("Width must be even");
  end
  // Masked lanes keep old data and are not driven
  always_comb begin
    lane_mask = {{H{~upper_n}}, {H{~lower_n}}}; // RULE8
    merged    = (new_word & lane_mask) | (old_word & ~lane_mask); // RULE9
  end
endmodule // ram_byte_lanes
`default_nettype wire

/* File: sim/ram_die_chk_asserts.sv */
// Checker for the stacked RAM die select logic.
// Assumes outputs follow the pins one clock later.
`timescale 1ns/1ns
`default_nettype none
module ram_die_chk (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  // Pins
  input wire logic [1:0]  PRAM_SELECT_N,
  input wire logic        STATIC_RAM_SELECT_LOW,
  input wire logic        STATIC_RAM_SELECT_HIGH,
  input wire logic        RAM_OUTPUT_ENABLE_N,
  input wire logic        RAM_WRITE_ENABLE_N,
  input wire logic        RAM_UPPER_BYTE_ENABLE_N,
  input wire logic        RAM_LOWER_BYTE_ENABLE_N,
  // Outputs
  input wire logic [15:0] DQ_OE,
  input wire logic        WAIT_OE,
  input wire logic        WAIT_OUT,
  input wire logic [1:0]  PRAM_STANDBY,
  input wire logic        SRAM_STANDBY,
  input wire logic        PRAM_LOW_POWER
);
  // One domain, so clock and reset are set once
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  a_die0_sel_active: assert property (!PRAM_SELECT_N[0] |=> !PRAM_STANDBY[0])
    else $error("die0 stays in standby while selected");
  a_die0_standby: assert property (PRAM_SELECT_N[0] |=> PRAM_STANDBY[0])
    else $error("die0 active while deselected");
  a_die1_own_sel: assert property (1'b1 |=> PRAM_STANDBY[1] == $past(PRAM_SELECT_N[1]))
    else $error("die1 standby not tied to its own select");
  a_sram_both_sel: assert property (!STATIC_RAM_SELECT_LOW && STATIC_RAM_SELECT_HIGH |=> !SRAM_STANDBY)
    else $error("static die not selected");
  a_sram_either_off: assert property (STATIC_RAM_SELECT_LOW || !STATIC_RAM_SELECT_HIGH |=> SRAM_STANDBY)
    else $error("static die selected with a select off");
  a_idle_bus_free: assert property (&PRAM_SELECT_N && (STATIC_RAM_SELECT_LOW || !STATIC_RAM_SELECT_HIGH)
    |=> DQ_OE == 16'h0000 && !WAIT_OE)
    else $error("outputs driven with no die selected");
  a_oe_high_free: assert property (RAM_OUTPUT_ENABLE_N |=> DQ_OE == 16'h0000)
    else $error("data driven with output enable high");
  a_upper_masked: assert property (RAM_UPPER_BYTE_ENABLE_N |=> DQ_OE[15:8] == 8'h00)
    else $error("upper lane driven while masked");
  a_lower_masked: assert property (RAM_LOWER_BYTE_ENABLE_N |=> DQ_OE[7:0] == 8'h00)
    else $error("lower lane driven while masked");
  a_read_lanes_on: assert property (!PRAM_SELECT_N[0] && !RAM_OUTPUT_ENABLE_N && RAM_WRITE_ENABLE_N
    && !RAM_UPPER_BYTE_ENABLE_N && !RAM_LOWER_BYTE_ENABLE_N |=> DQ_OE == 16'hFFFF)
    else $error("read lanes not driven");
  // Asynchronous reads never stall, so a driven wait pin reads valid
  a_wait_driven: assert property (!(&PRAM_SELECT_N) && !RAM_OUTPUT_ENABLE_N |=> WAIT_OE && !WAIT_OUT)
    else $error("wait pin not driven valid while selected");
  // Main scenarios reached
  c_read: cover property (DQ_OE == 16'hFFFF);
  c_sram: cover property (!SRAM_STANDBY);
  c_low_power: cover property ($rose(PRAM_LOW_POWER));
endmodule // ram_die_chk
bind stacked_ram_die_select_logic ram_die_chk u_chk (.*);
`default_nettype wire

/* File: sim/ram_host_model.sv */
// Host controller model driving the RAM control pins.
// Assumes the bench calls acc; pins change at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module ram_host_model (
  // Clock and returned data
  input wire logic         CLK_SYS,
  input wire logic [15:0]  DQ_OUT,
  input wire logic [15:0]  DQ_OE,
  // Control pins
  output logic [1:0]       PRAM_SELECT_N,
  output logic             PRAM_CFG_REG_ENABLE,
  output logic             PRAM_MODE_N,
  output logic             PRAM_ASYNC_ONLY,
  output logic             STATIC_RAM_SELECT_LOW,
  output logic             STATIC_RAM_SELECT_HIGH,
  output logic             RAM_OUTPUT_ENABLE_N,
  output logic             RAM_WRITE_ENABLE_N,
  output logic             RAM_UPPER_BYTE_ENABLE_N,
  output logic             RAM_LOWER_BYTE_ENABLE_N,
  output logic             RAM_REG_SELECT,
  output logic [7:0]       ADDR,
  output logic [15:0]      DQ_IN
);
  logic async_r = 1'b0;
  assign PRAM_ASYNC_ONLY = async_r;
  // Idle: nothing selected, bus scrambled so stale data never matches
  task automatic idle();
    PRAM_SELECT_N = 2'b11;
    STATIC_RAM_SELECT_LOW = 1'b1;
    STATIC_RAM_SELECT_HIGH = 1'b0;
    RAM_OUTPUT_ENABLE_N = 1'b1;
    RAM_WRITE_ENABLE_N = 1'b1;
    DQ_IN = ~DQ_IN;
  endtask
  // Sel: 0 die0, 1 die1, 2 static, 3 static half-selected, 4 none
  task automatic acc(input logic [2:0] sel, input logic cfg, rs, wr, oe_n, ub_n, lb_n,
                     input logic [7:0] a, input logic [15:0] d, output logic [15:0] q, qoe);
    @(negedge CLK_SYS);
    PRAM_SELECT_N = {sel != 3'd1, sel != 3'd0};
    STATIC_RAM_SELECT_LOW = !(sel == 3'd2 || sel == 3'd3);
    STATIC_RAM_SELECT_HIGH = sel == 3'd2;
    PRAM_CFG_REG_ENABLE = cfg & !async_r;
    PRAM_MODE_N = !(cfg & async_r);
    RAM_REG_SELECT = rs;
    RAM_OUTPUT_ENABLE_N = oe_n;
    RAM_WRITE_ENABLE_N = !wr;
    RAM_UPPER_BYTE_ENABLE_N = ub_n;
    RAM_LOWER_BYTE_ENABLE_N = lb_n;
    ADDR = a;
    DQ_IN = d;
    @(negedge CLK_SYS);
    q = DQ_OUT;
    qoe = DQ_OE;
    RAM_WRITE_ENABLE_N = 1'b1;
    @(negedge CLK_SYS);
    idle();
  endtask
  // Time-zero values
  initial begin
    DQ_IN = 16'h0000;
    ADDR = 8'h00;
    RAM_REG_SELECT = 1'b0;
    RAM_UPPER_BYTE_ENABLE_N = 1'b1;
    RAM_LOWER_BYTE_ENABLE_N = 1'b1;
    PRAM_CFG_REG_ENABLE = 1'b0;
    PRAM_MODE_N = 1'b1;
    idle();
  end
endmodule // ram_host_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the stacked RAM die select logic.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  wire logic [1:0] PRAM_SELECT_N, PRAM_STANDBY;
  wire logic PRAM_CFG_REG_ENABLE, PRAM_MODE_N, PRAM_ASYNC_ONLY, STATIC_RAM_SELECT_LOW, STATIC_RAM_SELECT_HIGH;
  wire logic RAM_OUTPUT_ENABLE_N, RAM_WRITE_ENABLE_N, RAM_UPPER_BYTE_ENABLE_N, RAM_LOWER_BYTE_ENABLE_N;
  wire logic RAM_REG_SELECT, WAIT_OUT, WAIT_OE, SRAM_STANDBY, PRAM_LOW_POWER;
  wire logic [7:0] ADDR;
  wire logic [15:0] DQ_IN, DQ_OUT, DQ_OE;
  int fail_count = 0;
  int tests_run = 0;
  logic [15:0] q, qoe;
  typedef struct packed {logic [2:0] sel; logic cfg, rs, ub_n, lb_n; logic [15:0] d, e;} row_t;
  // Write then read back; later die0 rows prove earlier die0 data untouched
  row_t rows [7] = '{
    '{3'd0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h1111, 16'h1111},
    '{3'd1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h2222, 16'h2222},
    '{3'd2, 1'b0, 1'b0, 1'b0, 1'b0, 16'h3333, 16'h3333},
    '{3'd0, 1'b0, 1'b0, 1'b1, 1'b0, 16'hAAAA, 16'h11AA},
    '{3'd0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0055, 16'h0055},
    '{3'd0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h00AA, 16'h00AA},
    '{3'd0, 1'b0, 1'b0, 1'b1, 1'b1, 16'hFFFF, 16'h11AA}};
  stacked_ram_die_select_logic u_dut (.*);
  ram_host_model u_host (.*);
  always #2 CLK_SYS = ~CLK_SYS;
  // Compare and count
  task automatic check(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog far beyond the roughly 70 cycles needed
  initial begin
    #40000;
    fail_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (5) @(negedge CLK_SYS);
    RSTN = 1'b1;
    foreach (rows[i]) begin
      u_host.acc(rows[i].sel, rows[i].cfg, rows[i].rs, 1'b1, 1'b1, rows[i].ub_n, rows[i].lb_n, 8'h21, rows[i].d, q, qoe);
      u_host.acc(rows[i].sel, rows[i].cfg, rows[i].rs, 1'b0, 1'b0, 1'b0, 1'b0, 8'h21, 16'h0000, q, qoe);
      check(q, rows[i].e);
    end
    u_host.acc(3'd0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h21, 16'h0000, q, qoe);
    check(qoe, 16'h0000);
    u_host.acc(3'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h21, 16'h0000, q, qoe);
    check(qoe, 16'hFF00);
    u_host.acc(3'd4, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h21, 16'h0000, q, qoe);
    check(qoe, 16'h0000);
    u_host.acc(3'd3, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h21, 16'hDEAD, q, qoe);
    u_host.acc(3'd2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h21, 16'h0000, q, qoe);
    check(q, 16'h3333);
    u_host.async_r = 1'b1;
    u_host.acc(3'd0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 16'h0001, q, qoe);
    check({15'h0000, PRAM_LOW_POWER}, 16'h0001);
    u_host.acc(3'd0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 16'h0000, q, qoe);
    check({15'h0000, PRAM_LOW_POWER}, 16'h0001);
    RSTN = 1'b0;
    #1;
    check({DQ_OE[11:0], PRAM_LOW_POWER, PRAM_STANDBY, SRAM_STANDBY}, 16'h0007);
    check({DQ_OE[14:0], WAIT_OE}, 16'h0000);
    check({15'h0000, WAIT_OUT}, 16'h0000);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
